// *** common/scc_regs.svh ***
// Purpose: Constants for the synchronism-check and close control block
// Assumes: Voltages in 0.01 %Un, angles in 0.001 deg, frequency in 0.001 Hz, times in 0.005 s steps
// Notes: Settings are plain ports; these are codes and defaults
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_FORCE_NORMAL 3'h0
`define SCC_FORCE_S1_BLK 3'h1
`define SCC_FORCE_S1_OK 3'h2
`define SCC_FORCE_S2_BLK 3'h3
`define SCC_FORCE_S2_OK 3'h4
`define SCC_FORCE_S3_BLK 3'h5
`define SCC_FORCE_S3_OK 3'h6
`define SCC_REF_NONE 3'h0
`define SCC_REF_AB 3'h1
`define SCC_REF_BC 3'h2
`define SCC_REF_CA 3'h3
`define SCC_REF_PH_A 3'h4
`define SCC_REF_PH_C 3'h6
`define SCC_UDIFF_DEF 16'h00C8
`define SCC_ULIVE_DEF 16'h07D0
`define SCC_UDEAD_DEF 16'h07D0
`define SCC_ADIFF_DEF 20'h00BB8
`define SCC_FDIFF_DEF 16'h0064
`define SCC_BKTIME_DEF 20'h0000A
`define SCC_TURN_MDEG 20'h57E40
`define SCC_STEP_US 32'd5000
`define SCC_CYCLE_US 32'd5000
`endif

// *** common/scc_pkg.sv ***
// Purpose: Types for the synchronism-check and close control block
// Assumes: Shared with the verification side
// Notes: Sequencer states for the per-cycle evaluation
package scc_pkg;
  typedef enum logic [1:0] {SCC_IDLE, SCC_SAMPLE, SCC_EVAL, SCC_PUBLISH} scc_state_e;
  typedef logic [2:0] scc_ref_t;
endpackage

// *** design/scc_sync_check.sv ***
// Purpose: Three-stage synchronism supervision with timed close command for stage one
// Assumes: Measurements arrive from same-clock logic, one set per program cycle
// Notes: Blocking is sampled one clock after the cycle tick, before any evaluation
`timescale 1ns/1ps
`include "scc_regs.svh"

// Operation
// - Blocking input sampled at each program cycle start before evaluation.
// - Conditions met and not blocked assert phase_match_ok.
// - Blocking active when match appears gives blocked and stops that event.
// - Blocking arriving after match deasserts phase_match_ok.
// - Force setting drives a stage blocked or matched when forcing enabled.
// - Side selection picks which side is measured for dead/live.
// - Each stage has an enable, default off, no match, blocked or bypass outputs when off unless forced.
// - On-start mode checks only while the start input is active.
// - Stage one reference: none, line-to-line, or phase if channels allow.
// - Stage two reference: none or line-to-line, needs both aux sync channels.
// - Stage three reference is its enable, aux a versus aux b only.
// - Auto close switching only for stage one, default off.
// - Close issued early by breaker time, steps 0.005 s, default 0.05 s.
// - Close routed to one of five objects, default first.
// - Estimated time to synchronism reported in 0.005 s steps.
// - Full slip rotation time reported in 0.005 s steps.
// - Signed angle difference reported in 0.001 deg, plus or minus one turn.
// - Synchronism needs voltage, angle and frequency differences under limits.
// - Live above live limit, dead below dead limit, dead off when zero.
module scc_sync_check #(
  parameter int NSTAGE = 3,
  parameter int NOBJ = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycle_tick,
  input wire logic [2:0] block_in,
  input wire logic [2:0] check_start_input,
  input wire logic [2:0] stage_enable,
  input wire logic [2:0] start_on_demand,
  input wire logic force_enable,
  input wire logic [2:0] status_force,
  input wire logic measure_line_side,
  input wire logic phase_volts_avail,
  input wire logic aux_a_sync_mode,
  input wire logic aux_b_sync_mode,
  input wire logic [2:0] stage_one_ref,
  input wire logic [2:0] stage_two_ref,
  input wire logic stage_three_ref,
  input wire logic [3:0] volt_cond_mask,
  input wire logic volt_bypass,
  input wire logic [15:0] u_diff_limit,
  input wire logic [15:0] u_live_limit,
  input wire logic [15:0] u_dead_limit,
  input wire logic [19:0] ang_diff_limit,
  input wire logic [15:0] freq_diff_limit,
  input wire logic [47:0] bus_volt,
  input wire logic [47:0] line_volt,
  input wire logic signed [59:0] ang_diff,
  input wire logic signed [47:0] freq_diff,
  input wire logic auto_close_switching,
  input wire logic [19:0] breaker_time,
  input wire logic [2:0] close_object_sel,
  output logic [2:0] phase_match_ok,
  output logic [2:0] stage_blocked,
  output logic [2:0] stage_bypass,
  output logic [NOBJ-1:0] close_cmd,
  output logic [19:0] est_close_time,
  output logic [19:0] rotate_time,
  output logic signed [19:0] placement_angle
);

  scc_pkg::scc_state_e state_r;
  scc_pkg::scc_state_e state_nxt;
  logic [2:0] blk_smp_r;
  logic [2:0] armed_r;
  logic [2:0] match_r;
  logic [2:0] blocked_r;
  logic [2:0] bypass_r;
  logic [NOBJ-1:0] close_r;
  logic [19:0] est_r;
  logic [19:0] rot_r;
  logic signed [19:0] place_r;
  logic [2:0] stage_ok;
  logic [2:0] stage_avail;
  logic [2:0] stage_run;
  logic [2:0] force_blk;
  logic [2:0] force_ok;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
    absd = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [19:0] abs20(input logic signed [19:0] v);
    abs20 = v[19] ? 20'(-v) : 20'(v);
  endfunction

  // Classify one side: bit1 live, bit0 dead
  function automatic logic [1:0] classify(input logic [15:0] v, input logic [15:0] live,
                                          input logic [15:0] dead);
    classify = {v > live, (dead != 16'h0000) && (v < dead)};
  endfunction

  // ----------------------------------------------------------------
  // Stage availability and per-stage comparison
  // ----------------------------------------------------------------
  // stage one reference legality
  wire s1_ref_ok = (stage_one_ref != `SCC_REF_NONE) &&
                   ((stage_one_ref <= `SCC_REF_CA) ||
                    (phase_volts_avail && stage_one_ref <= `SCC_REF_PH_C));
  // stage two needs both aux channels in sync mode
  wire s2_ref_ok = (stage_two_ref != `SCC_REF_NONE) && (stage_two_ref <= `SCC_REF_CA) &&
                   aux_a_sync_mode && aux_b_sync_mode;
  // stage three reference acts as its enable
  wire s3_ref_ok = stage_three_ref && aux_a_sync_mode && aux_b_sync_mode;
  assign stage_avail = {s3_ref_ok, s2_ref_ok, s1_ref_ok};
  assign stage_run = stage_enable & stage_avail & (~start_on_demand | check_start_input);

  genvar g;
  generate
    for (g = 0; g < NSTAGE; g++)
    begin : g_stage
      wire [15:0] ub = bus_volt[16*g +: 16];
      wire [15:0] ul = line_volt[16*g +: 16];
      wire [15:0] u_meas = measure_line_side ? ul : ub;
      wire [15:0] u_ref = measure_line_side ? ub : ul;
      wire [1:0] cm = classify(u_meas, u_live_limit, u_dead_limit);
      wire [1:0] cr = classify(u_ref, u_live_limit, u_dead_limit);
      wire ll = cm[1] && cr[1];
      wire ld = cr[1] && cm[0];
      wire dl = cr[0] && cm[1];
      wire dd = cr[0] && cm[0];
      wire vcond = volt_bypass || |(volt_cond_mask & {dd, dl, ld, ll});
      wire vdiff_ok = absd(ub, ul) < u_diff_limit;
      wire adiff_ok = abs20(ang_diff[20*g +: 20]) < ang_diff_limit;
      // Sign-extend the frequency slice so negative slip is not read as huge
      wire fdiff_ok = abs20({{4{freq_diff[16*g+15]}}, freq_diff[16*g +: 16]}) < {4'h0, freq_diff_limit};
      assign stage_ok[g] = vcond && (volt_bypass || (ll ? (vdiff_ok && adiff_ok && fdiff_ok) : 1'b1));
    end
  endgenerate

  assign force_blk = force_enable ? {status_force == `SCC_FORCE_S3_BLK, status_force == `SCC_FORCE_S2_BLK,
                                     status_force == `SCC_FORCE_S1_BLK} : 3'h0;
  assign force_ok = force_enable ? {status_force == `SCC_FORCE_S3_OK, status_force == `SCC_FORCE_S2_OK,
                                    status_force == `SCC_FORCE_S1_OK} : 3'h0;

  // ----------------------------------------------------------------
  // Blocking sequence per stage
  // ----------------------------------------------------------------
  wire [2:0] cond_now = stage_run & stage_ok;
  // A fresh condition with blocking present is latched as blocked until it drops
  // match and block resolution
  wire [2:0] match_nxt = (cond_now & ~blk_smp_r & ~(~armed_r & blocked_r) & ~force_blk) | force_ok;
  wire [2:0] blocked_nxt = ((cond_now & blk_smp_r & ~armed_r) | (cond_now & blocked_r & ~armed_r) |
                            force_blk) & ~force_ok;
  wire [2:0] armed_nxt = cond_now & ~blocked_nxt & (armed_r | ~blk_smp_r);

  // ----------------------------------------------------------------
  // Slip estimates for stage one
  // ----------------------------------------------------------------
  wire signed [19:0] ang1 = ang_diff[19:0];
  wire signed [15:0] f1 = freq_diff[15:0];
  wire [19:0] af1 = abs20({{4{f1[15]}}, f1});
  wire [19:0] aa1 = abs20(ang1);
  // Angle still to travel toward zero in the slip direction
  wire [19:0] togo = ((ang1[19] == f1[15]) && (ang1 != 20'sh00000)) ? 20'(`SCC_TURN_MDEG - aa1) : aa1;
  // mdeg / (mHz * 360) seconds, scaled into 0.005 s steps
  // rotation time
  wire [19:0] rot_calc = (af1 == 20'h00000) ? 20'hFFFFF : 20'(64'd200000 / (64'(af1)));
  wire [19:0] est_calc = (af1 == 20'h00000) ? 20'hFFFFF :
                         20'((64'(togo) * 64'd200) / (64'(af1) * 64'd360));
  wire close_go = auto_close_switching && match_r[0] && !blocked_r[0] && (est_calc <= breaker_time);
  logic [NOBJ-1:0] obj_dec;
  assign obj_dec = (close_object_sel < 3'(NOBJ)) ? NOBJ'(1) << close_object_sel : NOBJ'(0);

  // ----------------------------------------------------------------
  // Program-cycle sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    case (state_r)
      scc_pkg::SCC_IDLE: state_nxt = cycle_tick ? scc_pkg::SCC_SAMPLE : scc_pkg::SCC_IDLE;
      scc_pkg::SCC_SAMPLE: state_nxt = scc_pkg::SCC_EVAL;
      scc_pkg::SCC_EVAL: state_nxt = scc_pkg::SCC_PUBLISH;
      scc_pkg::SCC_PUBLISH: state_nxt = scc_pkg::SCC_IDLE;
      default: state_nxt = scc_pkg::SCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= scc_pkg::SCC_IDLE;
    else
      state_r <= state_nxt;
  end

  // blocking sampled first in the cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blk_smp_r <= 3'h0;
    else if (state_r == scc_pkg::SCC_SAMPLE)
      blk_smp_r <= block_in;
  end

  // ----------------------------------------------------------------
  // Stage status registers, written in the evaluation step
  // ----------------------------------------------------------------
  wire eval_now = (state_r == scc_pkg::SCC_EVAL);
  wire publish_now = (state_r == scc_pkg::SCC_PUBLISH);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      match_r <= 3'h0;
    else if (eval_now)
      match_r <= match_nxt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blocked_r <= 3'h0;
    else if (eval_now)
      blocked_r <= blocked_nxt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_r <= 3'h0;
    else if (eval_now)
      armed_r <= armed_nxt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bypass_r <= 3'h0;
    else if (eval_now)
      bypass_r <= stage_run & {3{volt_bypass}};
  end

  // ----------------------------------------------------------------
  // Close command and estimates, written in the publish step
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      close_r <= '0;
    else if (publish_now)
      close_r <= close_go ? obj_dec : '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      est_r <= 20'h00000;
    else if (publish_now)
      est_r <= est_calc;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rot_r <= 20'h00000;
    else if (publish_now)
      rot_r <= rot_calc;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      place_r <= 20'sh00000;
    else if (publish_now)
      place_r <= ang1;
  end

  assign phase_match_ok = match_r;
  assign stage_blocked = blocked_r;
  assign stage_bypass = bypass_r;
  assign close_cmd = close_r;
  assign est_close_time = est_r;
  assign rotate_time = rot_r;
  assign placement_angle = place_r;

endmodule

// *** test/scc_checker.sv ***
// Purpose: Port-level properties of the sync check block
// Assumes: Program cycle ticks at least four clocks apart
// Notes: Bound to every scc_sync_check instance
`timescale 1ns/1ps
module scc_checker #(
  parameter int NOBJ = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycle_tick,
  input wire logic [2:0] block_in,
  input wire logic [2:0] stage_enable,
  input wire logic force_enable,
  input wire logic auto_close_switching,
  input wire logic [2:0] close_object_sel,
  input wire logic [2:0] phase_match_ok,
  input wire logic [2:0] stage_blocked,
  input wire logic [NOBJ-1:0] close_cmd
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_off_quiet;
    cycle_tick ##2 (!stage_enable[1] && !force_enable) |=> !phase_match_ok[1] && !stage_blocked[1];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled stage active");
  property p_upd_time;
    $changed(phase_match_ok) || $changed(stage_blocked) |-> $past(cycle_tick, 3);
  endproperty
  a_upd_time: assert property (p_upd_time) else $error("status changed off cycle");
  property p_blk_drop;
    cycle_tick ##1 (block_in[0] && !force_enable) |=> ##1 !phase_match_ok[0];
  endproperty
  a_blk_drop: assert property (p_blk_drop) else $error("match while blocked");
  property p_excl;
    !(|(phase_match_ok & stage_blocked));
  endproperty
  a_excl: assert property (p_excl) else $error("match and blocked together");
  property p_close_sel;
    $changed(close_cmd) && (|close_cmd) |-> close_cmd == (NOBJ'(1) << close_object_sel);
  endproperty
  a_close_sel: assert property (p_close_sel) else $error("close to wrong object");
  property p_close_match;
    $rose(|close_cmd) |-> phase_match_ok[0] && !stage_blocked[0];
  endproperty
  a_close_match: assert property (p_close_match) else $error("close without match");
  property p_close_off;
    !auto_close_switching |-> close_cmd == '0;
  endproperty
  a_close_off: assert property (p_close_off) else $error("close while switching off");
  property p_close_time;
    $changed(close_cmd) |-> $past(cycle_tick, 4);
  endproperty
  a_close_time: assert property (p_close_time) else $error("close changed off cycle");
endmodule
bind scc_sync_check scc_checker #(.NOBJ(NOBJ)) u_chk (.*);

// *** test/scc_partner.sv ***
// Purpose: Blocking matrix, start inputs and breaker objects
// Assumes: Requests come from the bench
// Notes: Counts close commands taken by the objects
`timescale 1ns/1ps
module scc_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] blk_req,
  input wire logic [2:0] start_req,
  input wire logic [4:0] close_cmd,
  output logic [2:0] block_in,
  output logic [2:0] check_start_input,
  output int close_seen
);
  logic any_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      block_in <= 3'h0;
      check_start_input <= 3'h0;
      any_r <= 1'b0;
      close_seen <= 0;
    end
    else
    begin
      block_in <= blk_req;
      check_start_input <= start_req;
      any_r <= |close_cmd;
      if ((|close_cmd) && !any_r)
        close_seen <= close_seen + 1;
    end
  end
endmodule

// *** test/synchrocheck_block_and_close_control_tb_top.sv ***
// Purpose: Self-checking bench for scc_sync_check
// Assumes: Stage one supervised, stages two and three enabled only from the forcing steps until the close steps
// Notes: Model tracks stage one match and blocked state
`timescale 1ns/1ps
`include "scc_regs.svh"
module synchrocheck_block_and_close_control_tb_top;
  logic clk, rst_n, cycle_tick, force_enable, measure_line_side, phase_volts_avail, volt_bypass;
  logic aux_a_sync_mode, aux_b_sync_mode, stage_three_ref, auto_close_switching;
  logic [2:0] block_in, check_start_input, stage_enable, start_on_demand, status_force, stage_one_ref;
  logic [2:0] stage_two_ref, close_object_sel, phase_match_ok, stage_blocked, stage_bypass, blk_req, start_req;
  logic [3:0] volt_cond_mask;
  logic [15:0] u_diff_limit, u_live_limit, u_dead_limit, freq_diff_limit, v;
  logic [19:0] ang_diff_limit, breaker_time, est_close_time, rotate_time;
  logic signed [19:0] placement_angle;
  logic [47:0] bus_volt, line_volt;
  logic signed [59:0] ang_diff;
  logic signed [47:0] freq_diff;
  logic [4:0] close_cmd;
  int fails, num_checks, close_seen, pm, pb, em, eb, ea, ef, af, aa, tg, ee;
  logic [2:0] eby;
  scc_sync_check dut (.*);
  scc_partner u_far (.*);
  always #4 clk = ~clk;
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Random measurements, all stages alike
  task automatic setc(input int ok);
    v = 16'(16'h0BB8 + $urandom_range(16'h1F40));
    ea = ok ? $urandom_range(12'hBB7) : 12'hC1C + $urandom_range(16'h1388);
    if ($urandom_range(1))
      ea = -ea;
    ef = int'($urandom_range(8'hC6)) - 32'h63;
    bus_volt <= {3{v}};
    line_volt <= {3{v}};
    ang_diff <= {3{20'(ea)}};
    freq_diff <= {3{16'(ef)}};
    u_dead_limit <= 16'($urandom_range(16'h07D0));
    measure_line_side <= 1'($urandom_range(1));
    volt_cond_mask <= {3'($urandom_range(7)), 1'b1};
  endtask
  // One program cycle, then model prediction
  task automatic cyc(input int c, input int blk, input logic [2:0] fm, input logic [2:0] fb);
    blk_req <= blk ? 3'h1 : 3'h0;
    repeat (2) @(posedge clk);
    cycle_tick <= 1'b1;
    @(posedge clk);
    cycle_tick <= 1'b0;
    repeat (4) @(posedge clk);
    em = c && (blk ? 0 : !pb);
    eb = c && (blk ? !pm : pb);
    cmp(20'(phase_match_ok), 20'(fm) | 20'(em));
    cmp(20'(stage_blocked), 20'(fb) | 20'(eb));
    af = ef < 0 ? -ef : ef;
    aa = ea < 0 ? -ea : ea;
    tg = ((ea < 0) == (ef < 0) && ea != 0) ? 32'h00057E40 - aa : aa;
    ee = af == 0 ? 20'hFFFFF : tg * 32'hC8 / (32'h168 * af);
    cmp(placement_angle, 20'(ea));
    cmp(rotate_time, af == 0 ? 20'hFFFFF : 20'(32'h00030D40 / af));
    cmp(est_close_time, 20'(ee));
    cmp(20'(stage_bypass), 20'(eby));
    cmp(20'(close_cmd), (auto_close_switching && (em || fm[0]) && !(eb || fb[0]) && ee <= breaker_time &&
        close_object_sel < 3'h5) ? 20'h00001 << close_object_sel : 20'h00000);
    pm = em;
    pb = eb;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim();
  end
  initial
  begin
    {clk, cycle_tick, force_enable, aux_a_sync_mode, aux_b_sync_mode, stage_three_ref, volt_bypass} = '0;
    {auto_close_switching, blk_req, start_req, stage_enable, start_on_demand, status_force} = '0;
    {stage_two_ref, close_object_sel, bus_volt, line_volt, ang_diff, freq_diff, measure_line_side} = '0;
    {rst_n, phase_volts_avail, stage_one_ref, volt_cond_mask} = {2'h1, `SCC_REF_AB, 4'h1};
    u_diff_limit = `SCC_UDIFF_DEF;
    u_live_limit = `SCC_ULIVE_DEF;
    u_dead_limit = `SCC_UDEAD_DEF;
    ang_diff_limit = `SCC_ADIFF_DEF;
    freq_diff_limit = `SCC_FDIFF_DEF;
    breaker_time = 20'hFFFFF;
    eby = 3'h0;
    void'($urandom(32'h80FDE9B0));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    setc(1);
    cyc(0, 0, 3'h0, 3'h0);
    stage_enable <= 3'h1;
    for (int r = 1; r < 7; r++)
    begin
      stage_one_ref <= 3'(r);
      setc(1);
      cyc(1, 0, 3'h0, 3'h0);
    end
    cyc(1, 1, 3'h0, 3'h0);
    setc(0);
    cyc(0, 0, 3'h0, 3'h0);
    setc(1);
    cyc(1, 1, 3'h0, 3'h0);
    cyc(1, 0, 3'h0, 3'h0);
    setc(0);
    cyc(0, 0, 3'h0, 3'h0);
    start_on_demand <= 3'h1;
    setc(1);
    cyc(0, 0, 3'h0, 3'h0);
    start_req <= 3'h1;
    cyc(1, 0, 3'h0, 3'h0);
    setc(0);
    {start_on_demand, stage_enable, aux_a_sync_mode, aux_b_sync_mode, stage_three_ref, force_enable} <= {3'h0, 3'h7, 4'hF};
    stage_two_ref <= `SCC_REF_AB;
    for (int f = 1; f < 7; f++)
    begin
      status_force <= 3'(f);
      cyc(0, 0, f % 2 ? 3'h0 : 3'(1 << (f - 1) / 2), f % 2 ? 3'(1 << (f - 1) / 2) : 3'h0);
    end
    force_enable <= 1'b0;
    cyc(0, 0, 3'h0, 3'h0);
    volt_bypass <= 1'b1;
    eby = 3'h7;
    setc(0);
    cyc(1, 0, 3'h6, 3'h0);
    {volt_bypass, phase_volts_avail} <= 2'h0;
    eby = 3'h0;
    setc(1);
    cyc(0, 0, 3'h6, 3'h0);
    phase_volts_avail <= 1'b1;
    {stage_enable, auto_close_switching} <= 4'h3;
    for (int s = 0; s < 6; s++)
    begin
      close_object_sel <= 3'(s);
      breaker_time <= s[0] ? 20'($urandom_range(20'h3FFFF)) : `SCC_BKTIME_DEF;
      setc(1);
      cyc(1, 0, 3'h0, 3'h0);
    end
    cmp(20'(close_seen != 0), 20'h1);
    end_sim();
  end
endmodule
